/* tdu_map.svh */
// Behaviour
// RULE1 - Unsupported opcode or data type traps illegal-instruction; vector holds opcode/format or type.
// RULE2 - Opcode-specific trap vector combines opcode-identifying bits with trap-kind bits.
// RULE3 - Packed array load/store traps vector to eight-slot inline handler location.
// RULE4 - Each general trap has one fixed vector independent of opcode.
// RULE5 - Window-needing instruction whose incremented pointer hits overflow limit takes overflow trap.
// RULE6 - Window overflow beats an already trapping or interrupted instruction.
// RULE7 - Return making pointer equal underflow limit takes underflow trap.
// RULE8 - Take-completion bit set means completion trap on the next instruction.
// RULE9 - Take-completion bit set by completion, call or return with matching enable.
// RULE10 - Fetch bus or ECC error traps only for executed instructions.
// RULE11 - Load errors and read-before-write store errors trap; write errors ignored.
// RULE12 - Load map miss only when both data cache and map cache miss.
// RULE13 - Identity-mapped region addresses never raise map-miss traps.
// RULE14 - Store without mapping raises store map miss, distinct vector from load.
// RULE15 - Fetch missing cache and map cache raises instruction map miss.
// RULE16 - Branch target or long immediate into oldspace on enabled page traps.
// RULE17 - Listed loads reading oldspace pointer from enabled page take data transport trap.
// RULE18 - Memory operation class requests error, monitor, bound or logic-variable traps.
// RULE19 - Write-protected page suppresses store write and traps.
// RULE20 - Clear modified bit suppresses store write and traps.
// RULE21 - Pointer with zero bits 31:27 selects ephemeral bit by 25:24; zero bit traps.
// RULE22 - Same-group store address and data bits 25:21 suppress ephemeral trap.
// RULE23 - Any trap advances window pointer and pushes trapping instruction PC.
// RULE24 - Trap places control register, source1, source2 into A0, A1, A2.
// RULE25 - Vector address is trap base register combined with trap offset.
// RULE26 - Several non-overflow traps on one instruction report one by fixed priority.
`ifndef TDU_MAP_SVH
`define TDU_MAP_SVH
`define TDU_VEC_TOP       5'h1f
`define TDU_OFS_ILL_OP    3'h7
`define TDU_OFS_ILL_TYPE  4'hd
`define TDU_OFS_MISC      5'h1d
`define TDU_OFS_GENERAL   9'h1fc
`define TDU_G_WB_OVF      5'h00
`define TDU_G_WB_UNF      5'h01
`define TDU_G_COMPLETE    5'h02
`define TDU_G_IFETCH_ERR  5'h03
`define TDU_G_DATA_ERR    5'h04
`define TDU_G_LOAD_MISS   5'h05
`define TDU_G_STORE_MISS  5'h06
`define TDU_G_IMAP_MISS   5'h07
`define TDU_G_ITRANSPORT  5'h08
`define TDU_G_DTRANSPORT  5'h09
`define TDU_G_MOT_ERROR   5'h0a
`define TDU_G_MOT_MONITOR 5'h0b
`define TDU_G_MOT_BOUND   5'h0c
`define TDU_G_MOT_LVAR    5'h0d
`define TDU_G_WRITE_PROT  5'h0e
`define TDU_G_PAGE_MOD    5'h0f
`define TDU_G_EPHEMERAL   5'h10
`define TDU_OT_PACKED     2'h3
`define TDU_OT_OVERFLOW   2'h1
`define TDU_OT_BASIC      2'h0
`define TDU_MISC_LOAD_ARR  4'h2
`define TDU_MISC_STORE_ARR 4'h6
`define TDU_EPH_HI        31
`define TDU_EPH_LO        27
`define TDU_WB_W          4
`endif

/* tdu_pkg.sv */
`default_nettype none
package tdu_pkg;
  typedef enum logic [1:0] {
    MOT_NONE,
    MOT_ERROR,
    MOT_MONITOR,
    MOT_BOUND
  } tdu_mot_e;

  typedef struct packed {
    logic        valid;
    logic [31:0] pc;
    logic [5:0]  opcode;
    logic [2:0]  format;
    logic        illegal_op;
    logic        illegal_type;
    logic [5:0]  bad_type;
    logic        misc_trap;
    logic [3:0]  misc_code;
    logic [1:0]  misc_kind;
    logic        needs_window;
    logic        is_call;
    logic        is_return;
    logic        interrupted;
    logic [31:0] ctrl;
    logic [31:0] src1;
    logic [31:0] src2;
  } tdu_instr_s;

  typedef struct packed {
    logic        fetch_err;
    logic        fetch_cache_hit;
    logic        fetch_map_hit;
    logic        fetch_identity;
    logic        fetch_oldspace;
    logic        fetch_page_transport;
    logic        is_load;
    logic        is_store;
    logic        transport_load;
    logic        read_err;
    logic        dcache_hit;
    logic        map_hit;
    logic        identity;
    logic        data_ptr;
    logic        data_oldspace;
    logic        page_transport;
    logic        lvar;
    tdu_mot_e    mot;
    logic        write_prot;
    logic        modified;
    logic [3:0]  eph_bits;
    logic [31:0] addr;
    logic [31:0] wdata;
  } tdu_mem_s;

  typedef struct packed {
    logic        take;
    logic [31:0] vector;
    logic [31:0] push_pc;
    logic        wb_advance;
    logic        suppress_write;
    logic [31:0] a0;
    logic [31:0] a1;
    logic [31:0] a2;
  } tdu_trap_s;

  typedef struct packed {
    logic                 take_complete;
    logic [3:0]           wb_ptr;
    logic [17:0]          trap_base;
    logic                 trap_on_complete;
    logic                 trap_on_call;
    logic                 trap_on_return;
    logic [3:0]           ovf_limit;
    logic [3:0]           unf_limit;
    tdu_trap_s            out;
  } tdu_state_s;
endpackage
`default_nettype wire

/* tdu_trap_detect.sv */
// Strobed register access and the address map were left to the implementer.
`include "tdu_map.svh"
`default_nettype none
module tdu_trap_detect (
  input  wire logic               clk_i,
  input  wire logic               reset_n_i,
  input  wire logic               clk_en_i,
  input  wire tdu_pkg::tdu_instr_s instr_i,
  input  wire tdu_pkg::tdu_mem_s   mem_i,
  input  wire logic [3:0]         reg_addr_i,
  input  wire logic [31:0]        reg_wdata_i,
  input  wire logic               reg_wr_i,
  input  wire logic               reg_rd_i,
  output logic [31:0]             reg_rdata_o,
  output tdu_pkg::tdu_trap_s      trap_o
);

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [3:0] OFS_BASE   = 4'h0;
  localparam logic [3:0] OFS_CTRL   = 4'h1;
  localparam logic [3:0] OFS_WINDOW = 4'h2;

  tdu_pkg::tdu_state_s state_reg;
  tdu_pkg::tdu_state_s state_next;
  logic [31:0]         rdata_reg;
  logic [31:0]         rdata_next;

  // ----------------------------------------
  // Condition decode
  // ----------------------------------------
  logic [3:0]  wb_inc;
  logic        ovf_hit;
  logic        unf_hit;
  logic        eph_sel;
  logic        eph_trap;
  logic        store_miss;
  logic        load_miss;
  logic        imap_miss;
  logic        any_trap;
  logic        mem_op;
  logic        complete_set;
  logic [4:0]  gcode;
  logic        gen_hit;
  logic [13:0] offset;

  always_comb begin
    wb_inc    = state_reg.wb_ptr + 4'h1;
    mem_op    = mem_i.is_load || mem_i.is_store;
    unf_hit   = instr_i.valid && instr_i.is_return &&
                ((state_reg.wb_ptr - 4'h1) == state_reg.unf_limit);              // [RULE7]
    eph_sel   = mem_i.eph_bits[mem_i.wdata[25:24]];                               // [RULE21]
    eph_trap  = mem_i.is_store && mem_i.data_ptr &&
                (mem_i.wdata[`TDU_EPH_HI:`TDU_EPH_LO] == 5'h00) && !eph_sel &&
                !((mem_i.addr[`TDU_EPH_HI:`TDU_EPH_LO] == 5'h00) &&
                  (mem_i.addr[25:21] == mem_i.wdata[25:21]));                     // [RULE22]
    load_miss  = mem_i.is_load && !mem_i.dcache_hit && !mem_i.map_hit &&
                 !mem_i.identity;                                                 // [RULE12] [RULE13]
    store_miss = mem_i.is_store && !mem_i.map_hit && !mem_i.identity;             // [RULE14] [RULE13]
    imap_miss  = !mem_i.fetch_cache_hit && !mem_i.fetch_map_hit &&
                 !mem_i.fetch_identity;                                           // [RULE15] [RULE13]
    gen_hit = 1'b1;
    // Fixed priority, first match wins
    if (state_reg.take_complete)                                     gcode = `TDU_G_COMPLETE;   // [RULE8] [RULE26]
    else if (mem_i.fetch_err)                                        gcode = `TDU_G_IFETCH_ERR; // [RULE10]
    else if (imap_miss)                                              gcode = `TDU_G_IMAP_MISS;
    else if (mem_i.fetch_oldspace && mem_i.fetch_page_transport)     gcode = `TDU_G_ITRANSPORT; // [RULE16]
    else if (unf_hit)                                                gcode = `TDU_G_WB_UNF;
    else if ((mem_i.is_load || mem_i.is_store) && mem_i.read_err)    gcode = `TDU_G_DATA_ERR;   // [RULE11]
    else if (load_miss)                                              gcode = `TDU_G_LOAD_MISS;
    else if (store_miss)                                             gcode = `TDU_G_STORE_MISS;
    else if (mem_i.is_load && mem_i.transport_load && mem_i.data_ptr && mem_i.data_oldspace &&
             mem_i.page_transport)                                   gcode = `TDU_G_DTRANSPORT; // [RULE17]
    else if (mem_op && mem_i.mot == tdu_pkg::MOT_ERROR)              gcode = `TDU_G_MOT_ERROR;  // [RULE18]
    else if (mem_op && mem_i.mot == tdu_pkg::MOT_MONITOR)            gcode = `TDU_G_MOT_MONITOR;
    else if (mem_op && mem_i.mot == tdu_pkg::MOT_BOUND)              gcode = `TDU_G_MOT_BOUND;
    else if (mem_op && mem_i.lvar)                                   gcode = `TDU_G_MOT_LVAR;
    else if (mem_i.is_store && mem_i.write_prot)                     gcode = `TDU_G_WRITE_PROT; // [RULE19]
    else if (mem_i.is_store && !mem_i.modified)                      gcode = `TDU_G_PAGE_MOD;   // [RULE20]
    else if (eph_trap)                                               gcode = `TDU_G_EPHEMERAL;
    else begin
      gcode   = `TDU_G_WB_OVF;
      gen_hit = 1'b0;
    end
    ovf_hit = instr_i.valid && (instr_i.needs_window || instr_i.interrupted || gen_hit ||
              instr_i.illegal_op || instr_i.illegal_type || instr_i.misc_trap) &&
              (wb_inc == state_reg.ovf_limit);                                    // [RULE5]
    // Offset selection
    if (ovf_hit) begin
      offset = {`TDU_OFS_GENERAL, `TDU_G_WB_OVF};                                 // [RULE6] [RULE4]
    end else if (gen_hit) begin
      offset = {`TDU_OFS_GENERAL, gcode};                                         // [RULE4]
    end else if (instr_i.illegal_op) begin
      offset = {`TDU_OFS_ILL_OP, 2'b00, instr_i.format[2:0], instr_i.opcode};     // [RULE1]
    end else if (instr_i.illegal_type) begin
      offset = {`TDU_OFS_ILL_TYPE, 4'h0, instr_i.bad_type};                       // [RULE1]
    end else if (instr_i.misc_trap && instr_i.misc_kind == `TDU_OT_PACKED &&
                 (instr_i.misc_code == `TDU_MISC_LOAD_ARR ||
                  instr_i.misc_code == `TDU_MISC_STORE_ARR)) begin
      offset = {`TDU_OFS_MISC, instr_i.misc_code, instr_i.misc_kind, 3'b000};     // [RULE3]
    end else begin
      offset = {`TDU_OFS_MISC, instr_i.misc_code, instr_i.misc_kind, 3'b000};     // [RULE2]
    end
    any_trap = instr_i.valid && (ovf_hit || gen_hit || instr_i.illegal_op ||
               instr_i.illegal_type || instr_i.misc_trap);
    complete_set = instr_i.valid && !any_trap &&
                   (state_reg.trap_on_complete ||
                    (instr_i.is_call && state_reg.trap_on_call) ||
                    (instr_i.is_return && state_reg.trap_on_return));            // [RULE9]
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    rdata_next = 32'h0000_0000;
    state_next.out.take           = 1'b0;
    state_next.out.wb_advance     = 1'b0;
    state_next.out.suppress_write = 1'b0;
    if (reg_wr_i) begin
      case (reg_addr_i)
        OFS_BASE:   state_next.trap_base = reg_wdata_i[31:14];
        OFS_CTRL: begin
          state_next.trap_on_complete = reg_wdata_i[0];
          state_next.trap_on_call     = reg_wdata_i[1];
          state_next.trap_on_return   = reg_wdata_i[2];
          if (reg_wdata_i[3]) state_next.take_complete = 1'b0;
        end
        OFS_WINDOW: begin
          state_next.wb_ptr    = reg_wdata_i[3:0];
          state_next.ovf_limit = reg_wdata_i[11:8];
          state_next.unf_limit = reg_wdata_i[19:16];
        end
        default: ;
      endcase
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        OFS_BASE:   rdata_next = {state_reg.trap_base, 14'h0000};
        OFS_CTRL:   rdata_next = {28'h0000000, state_reg.take_complete, state_reg.trap_on_return,
                                  state_reg.trap_on_call, state_reg.trap_on_complete};
        OFS_WINDOW: rdata_next = {12'h000, state_reg.unf_limit, 4'h0, state_reg.ovf_limit,
                                  4'h0, state_reg.wb_ptr};
        default:    rdata_next = 32'h0000_0000;
      endcase
    end
    if (any_trap) begin
      state_next.out.take       = 1'b1;
      state_next.out.vector     = {state_reg.trap_base, offset};                  // [RULE25]
      state_next.out.push_pc    = instr_i.pc;                                     // [RULE23]
      state_next.out.wb_advance = 1'b1;                                           // [RULE23]
      state_next.wb_ptr         = wb_inc;
      state_next.out.suppress_write = mem_i.is_store;
      state_next.out.a0         = instr_i.ctrl;                                   // [RULE24]
      state_next.out.a1         = instr_i.src1;
      state_next.out.a2         = instr_i.src2;
      if (gcode == `TDU_G_COMPLETE && gen_hit && !ovf_hit) state_next.take_complete = 1'b0;
    end else if (instr_i.valid) begin
      if (instr_i.is_call) state_next.wb_ptr = wb_inc;
      else if (instr_i.is_return) state_next.wb_ptr = state_reg.wb_ptr - 4'h1;
    end
    if (complete_set) state_next.take_complete = 1'b1;                            // [RULE9]
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= '0;
      rdata_reg <= 32'h0000_0000;
    end else if (clk_en_i) begin
      state_reg <= state_next;
      rdata_reg <= rdata_next;
    end
  end

  assign trap_o      = state_reg.out;
  assign reg_rdata_o = rdata_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  ovf_wins_a: assert property (clk_en_i && ovf_hit |=> trap_o.take &&
    trap_o.vector[13:0] == {`TDU_OFS_GENERAL, `TDU_G_WB_OVF}) else $error("overflow not first"); // [RULE6]
  ovf_detect_a: assert property (clk_en_i && instr_i.valid && instr_i.needs_window &&
    (state_reg.wb_ptr + 4'h1) == state_reg.ovf_limit |=> trap_o.take) else $error("overflow missed"); // [RULE5]
  pc_push_a: assert property (clk_en_i && any_trap |=> trap_o.push_pc == $past(instr_i.pc) &&
    trap_o.wb_advance) else $error("trap pc wrong"); // [RULE23]
  args_a: assert property (clk_en_i && any_trap |=> trap_o.a0 == $past(instr_i.ctrl) &&
    trap_o.a2 == $past(instr_i.src2)) else $error("trap args wrong"); // [RULE24]
  base_use_a: assert property (clk_en_i && any_trap |=> trap_o.vector[31:14] ==
    $past(state_reg.trap_base)) else $error("base missing"); // [RULE25]
  identity_a: assert property (clk_en_i && any_trap && mem_i.identity && !ovf_hit |=>
    trap_o.vector[13:0] != {`TDU_OFS_GENERAL, `TDU_G_LOAD_MISS} &&
    trap_o.vector[13:0] != {`TDU_OFS_GENERAL, `TDU_G_STORE_MISS}) else $error("identity miss"); // [RULE13]
  complete_a: assert property (clk_en_i && state_reg.take_complete && instr_i.valid |=>
    trap_o.take) else $error("completion lost"); // [RULE8]
  dcache_load_a: assert property (clk_en_i && mem_i.is_load && !mem_i.is_store && mem_i.dcache_hit |->
    !load_miss) else $error("load miss on hit"); // [RULE12]
  store_suppr_a: assert property (clk_en_i && any_trap && mem_i.is_store && mem_i.write_prot |=>
    trap_o.suppress_write) else $error("write not stopped"); // [RULE19]

  ovf_c: cover property (clk_en_i && ovf_hit && instr_i.misc_trap);
  eph_c: cover property (clk_en_i && instr_i.valid && eph_trap);
  cmpl_c: cover property (clk_en_i && complete_set ##1 clk_en_i && instr_i.valid);

endmodule
`default_nettype wire

/* tdu_mem_model.sv */
`default_nettype none
module tdu_mem_model #(
  parameter logic [1:0] IDENT_TOP = 2'h3
) (
  input  wire tdu_pkg::tdu_mem_s req_i,
  input  wire logic [7:0]        page_cfg_i,
  output var  tdu_pkg::tdu_mem_s mem_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Map cache and data cache lookup
  // ----------------------------------------
  always_comb begin
    mem_o            = req_i;
    mem_o.identity   = (req_i.addr[31:30] == IDENT_TOP);
    mem_o.map_hit    = page_cfg_i[0];
    mem_o.dcache_hit = page_cfg_i[1];
    mem_o.write_prot = page_cfg_i[2];
    mem_o.modified   = page_cfg_i[3];
    mem_o.eph_bits   = page_cfg_i[7:4];
  end
endmodule
`default_nettype wire

/* trap_detection_unit_test.sv */
`default_nettype none
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin bad_count++; \
  $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module trap_detection_unit_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic                 clk_i = 1'b0;
  logic                 reset_n_i = 1'b0;
  tdu_pkg::tdu_instr_s  instr = '0;
  tdu_pkg::tdu_mem_s    req = '0;
  tdu_pkg::tdu_mem_s    mem;
  logic [7:0]           cfg = 8'h0b;
  logic [3:0]           reg_addr = 4'h0;
  logic [31:0]          reg_wdata = 32'h0;
  logic                 reg_wr = 1'b0;
  logic                 reg_rd = 1'b0;
  logic                 clk_en = 1'b1;
  logic [31:0]          rdata;
  tdu_pkg::tdu_trap_s   trap;
  logic [17:0]          base = 18'h2a5c3;
  logic [3:0]           wp = 4'h0;
  logic [3:0]           wo = 4'h0;
  logic [3:0]           wu = 4'h0;
  int                   bad_count = 0;
  int                   num_checks = 0;
  int                   seed = 32;
  always #12.5 clk_i = ~clk_i;
  tdu_mem_model u_model (.req_i(req), .page_cfg_i(cfg), .mem_o(mem));
  tdu_trap_detect u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en), .instr_i(instr), .mem_i(mem),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_rdata_o(rdata), .trap_o(trap));
  // ----------------------------------------
  // Expectation and bus tasks
  // ----------------------------------------
  function automatic logic [14:0] exp_trap(input tdu_pkg::tdu_instr_s i, input tdu_pkg::tdu_mem_s m,
      input logic [3:0] p, input logic [3:0] ov, input logic [3:0] un, input logic tc);
    logic ls;
    logic gh;
    logic t;
    logic [4:0] g;
    logic [13:0] o;
    ls = m.is_load | m.is_store;
    gh = 1'b1;
    t = 1'b1;
    g = 5'h00;
    if (tc) g = 5'h02;
    else if (m.fetch_err) g = 5'h03;
    else if (!m.fetch_cache_hit && !m.fetch_map_hit && !m.fetch_identity) g = 5'h07;
    else if (m.fetch_oldspace && m.fetch_page_transport) g = 5'h08;
    else if (i.is_return && (p - 4'h1 == un)) g = 5'h01;
    else if (ls && m.read_err) g = 5'h04;
    else if (m.is_load && !m.dcache_hit && !m.map_hit && !m.identity) g = 5'h05;
    else if (m.is_store && !m.map_hit && !m.identity) g = 5'h06;
    else if (m.is_load && m.transport_load && m.data_ptr && m.data_oldspace && m.page_transport) g = 5'h09;
    else if (ls && m.mot != tdu_pkg::MOT_NONE) g = 5'h09 + {3'h0, m.mot};
    else if (ls && m.lvar) g = 5'h0d;
    else if (m.is_store && m.write_prot) g = 5'h0e;
    else if (m.is_store && !m.modified) g = 5'h0f;
    else if (m.is_store && m.data_ptr && m.wdata[31:27] == 5'h0 && !m.eph_bits[m.wdata[25:24]]
             && !(m.addr[31:27] == 5'h0 && m.addr[25:21] == m.wdata[25:21])) g = 5'h10;
    else gh = 1'b0;
    o = {9'h1fc, g};
    if (!gh) begin
      if (i.illegal_op) o = {3'h7, 2'h0, i.format, i.opcode};
      else if (i.illegal_type) o = {4'hd, 4'h0, i.bad_type};
      else if (i.misc_trap) o = {5'h1d, i.misc_code, i.misc_kind, 3'h0};
      else t = 1'b0;
    end
    if ((t | i.needs_window | i.interrupted) && (p + 4'h1 == ov)) begin
      o = 14'h3f80;
      t = 1'b1;
    end
    return {t & i.valid, o};
  endfunction
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_i);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_i);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_i);
    reg_rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic set_window(input logic [3:0] p, input logic [3:0] ov, input logic [3:0] un);
    reg_write(4'h2, {12'h0, un, 4'h0, ov, 4'h0, p});
    wp = p;
    wo = ov;
    wu = un;
  endtask
  task automatic issue(input tdu_pkg::tdu_instr_s i, input tdu_pkg::tdu_mem_s m, input logic [7:0] c,
      input logic tc);
    logic [14:0] e;
    @(posedge clk_i);
    instr <= i;
    req <= m;
    cfg <= c;
    @(posedge clk_i);
    instr.valid <= 1'b0;
    #1;
    e = exp_trap(i, mem, wp, wo, wu, tc);
    `CHK("take", e[14], trap.take)
    `CHK("suppress", e[14] & m.is_store, trap.suppress_write)
    if (e[14]) begin
      wp = wp + 4'h1;
      `CHK("vector", {base, e[13:0]}, trap.vector)
      `CHK("push_pc", i.pc, trap.push_pc)
      `CHK("wb_adv", 1'b1, trap.wb_advance)
      `CHK("a0", i.ctrl, trap.a0)
      `CHK("a1", i.src1, trap.a1)
      `CHK("a2", i.src2, trap.a2)
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #1000000;
    bad_count++;
    tally_and_finish();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [159:0] r;
    logic [31:0] d;
    tdu_pkg::tdu_instr_s i;
    tdu_pkg::tdu_instr_s n;
    tdu_pkg::tdu_mem_s m;
    logic [3:0] mc [4];
    logic [1:0] mk [4];
    mc = '{4'h2, 4'h6, 4'h0, 4'h5};
    mk = '{2'h3, 2'h3, 2'h1, 2'h0};
    n = '0;
    n.valid = 1'b1;
    n.pc = 32'h0000_1234;
    n.ctrl = 32'h0000_00c5;
    n.src1 = 32'h1111_2222;
    n.src2 = 32'h3333_4444;
    m = '0;
    m.fetch_cache_hit = 1'b1;
    m.fetch_map_hit = 1'b1;
    repeat (6) @(posedge clk_i);
    reset_n_i <= 1'b1;
    reg_read(4'h0, d);
    `CHK("base_rst", 32'h0, d)
    reg_write(4'h0, {base, 14'h0});
    reg_read(4'h0, d);
    `CHK("base", {base, 14'h0}, d)
    reg_read(4'h9, d);
    `CHK("unmapped", 32'h0, d)
    $display("test registers done");
    set_window(4'h0, 4'h0, 4'h0);
    i = n;
    i.illegal_op = 1'b1;
    i.format = 3'h5;
    i.opcode = 6'h2b;
    issue(i, m, 8'h0b, 1'b0);
    `CHK("ill_op", {base, 3'h7, 2'h0, 3'h5, 6'h2b}, trap.vector)
    i = n;
    i.illegal_type = 1'b1;
    i.bad_type = 6'h3e;
    issue(i, m, 8'h0b, 1'b0);
    `CHK("ill_type", {base, 4'hd, 4'h0, 6'h3e}, trap.vector)
    for (int k = 0; k < 4; k++) begin
      i = n;
      i.misc_trap = 1'b1;
      i.misc_code = mc[k];
      i.misc_kind = mk[k];
      issue(i, m, 8'h0b, 1'b0);
      `CHK("misc", {base, 5'h1d, mc[k], mk[k], 3'h0}, trap.vector)
    end
    for (int k = 0; k < 8; k++) begin
      r[7:0] = k[7:0];
      m.is_store = r[0];
      m.is_load = ~r[0];
      m.addr = r[2] ? 32'hc000_0040 : 32'h0100_0040;
      issue(n, m, {6'h2, r[1], 1'b0} | 8'h08, 1'b0);
    end
    m.is_store = 1'b0;
    m.is_load = 1'b0;
    m.fetch_err = 1'b1;
    i = n;
    i.valid = 1'b0;
    issue(i, m, 8'h0b, 1'b0);
    m.fetch_err = 1'b0;
    $display("test vectors done");
    set_window(4'h3, 4'h4, 4'h0);
    i = n;
    i.illegal_op = 1'b1;
    issue(i, m, 8'h0b, 1'b0);
    `CHK("ovf_trap", {base, 14'h3f80}, trap.vector)
    reg_read(4'h2, d);
    `CHK("wb_ptr", 32'h0000_0404, d)
    set_window(4'h6, 4'h7, 4'h0);
    i = n;
    i.needs_window = 1'b1;
    i.is_call = 1'b1;
    issue(i, m, 8'h0b, 1'b0);
    set_window(4'h5, 4'hf, 4'h4);
    i = n;
    i.is_return = 1'b1;
    issue(i, m, 8'h0b, 1'b0);
    `CHK("unf_trap", {base, 14'h3f81}, trap.vector)
    for (int k = 0; k < 3; k++) begin
      set_window(4'h5, 4'hf, 4'h0);
      reg_write(4'h1, 32'h1 << k);
      i = n;
      i.is_call = (k == 1);
      i.needs_window = (k == 1);
      i.is_return = (k == 2);
      issue(i, m, 8'h0b, 1'b0);
      reg_read(4'h1, d);
      `CHK("tc_set", (32'h1 << k) | 32'h8, d)
      reg_write(4'h1, 32'h0);
      issue(n, m, 8'h0b, 1'b1);
      reg_read(4'h1, d);
      `CHK("tc_clr", 32'h0, d)
    end
    i = n;
    i.illegal_op = 1'b1;
    @(posedge clk_i);
    clk_en <= 1'b0;
    instr <= i;
    req <= m;
    @(posedge clk_i);
    instr.valid <= 1'b0;
    clk_en <= 1'b1;
    #1;
    `CHK("frozen", 1'b0, trap.take)
    $display("test window and completion done");
    for (int k = 0; k < 300; k++) begin
      r = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
      i = r[156:0];
      i.valid = 1'b1;
      r = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
      m = r[88:0];
      m.is_store = ~m.is_load;
      if (r[109]) m.wdata[31:27] = 5'h0;
      if (r[110]) m.addr[31:27] = 5'h0;
      if (r[111]) m.addr[25:21] = m.wdata[25:21];
      set_window(r[100:97], r[104:101], r[108:105]);
      issue(i, m, r[96:89], 1'b0);
    end
    $display("test random done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
